// file: rtl/tscc_pkg.sv
// constants shared by the time-slot interchange control core
// assumes one master clock for serial and host logic
package tscc_pkg;
	// frame shape: streams, channels, clocks per bit cell
	localparam int STREAMS = 4;
	localparam int CHANS = 128;
	localparam int CLKS_PER_BIT = 2;

	// register indices with A7 low
	localparam logic [6:0] REG_CTRL = 7'h00;
	localparam logic [6:0] REG_MODE = 7'h01;
	localparam logic [6:0] REG_FAR = 7'h02;
	localparam logic [6:0] REG_OFFS = 7'h03;

	// control_register fields
	localparam int CR_STREAM = 0;
	localparam int CR_MEMPICK = 4;
	localparam int CR_FILLMODE = 5;

	// interface_mode_select fields
	localparam int IMS_TRIG = 0;
	localparam int IMS_STANDBY = 1;
	localparam int IMS_GO = 2;
	localparam int IMS_PAT = 5;

	// frame_align_result fields
	localparam int FAR_DONE = 12;

	// connection location fields
	localparam int CM_CH = 0;
	localparam int CM_ST = 7;
	localparam int CM_PROC = 11;
	localparam int CM_CONST = 12;
	localparam int CM_DRIVE = 13;
	localparam int CM_LOOP = 14;
	localparam logic [10:0] CM_FILL_ZERO = 11'h000;

	// reset values
	localparam logic [15:0] CR_RST = 16'h0000;
	localparam logic [15:0] IMS_RST = 16'h0000;
	localparam logic [15:0] OFFS_RST = 16'h0000;

	// timing counts in master clocks, offset limit, channel gap and last fill location
	localparam logic [10:0] INPUT_LAG = 11'h005;
	localparam logic [10:0] MID_FRAME = 11'h400;
	localparam logic [3:0] OFFS_MAX = 4'h9;
	localparam logic [7:0] VAR_MIN_DELAY = 8'h03;
	localparam logic [8:0] FILL_LAST = 9'h1ff;

	// pin synchroniser width
	localparam int SYNC_W = 37;

	// host port access states
	typedef enum logic [2:0] {
		P_IDLE = 3'b001,
		P_ACT  = 3'b010,
		P_END  = 3'b100
	} tscc_port_t;
endpackage

// file: rtl/tscc_fifo2.sv
// two-entry valid/ready buffer for assembled input words
// assumes both sides on the same clock
`timescale 1ns/100ps
`default_nettype none
module tscc_fifo2 #(
	parameter int W = 41
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	logic [W-1:0] d0_q;
	logic [W-1:0] d1_q;
	logic [1:0]   cnt_q;
	logic         push;
	logic         pop;

	// handshake terms
	assign in_ready = (cnt_q != 2'd2);
	assign out_valid = (cnt_q != 2'd0);
	assign out_data = d0_q;
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// occupancy
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cnt_q <= 2'd0;
		else
			cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
	end

	// storage moves toward the head on a pop
	always_ff @(posedge clk)
	begin
		if (pop)
		begin
			d0_q <= (cnt_q == 2'd2) ? d1_q : in_data;
			d1_q <= in_data;
		end
		else if (push)
		begin
			if (cnt_q == 2'd0)
				d0_q <= in_data;
			else
				d1_q <= in_data;
		end
	end
endmodule
`default_nettype wire

// file: rtl/tscc_core.sv
// control core of a 512x512 time-slot interchange switch
// assumes pins arrive asynchronously; memories are flip-flops without reset
`timescale 1ns/100ps
`default_nettype none
// How it works
// [R1] environment gives master clock, quarter-rate measure clock and negative frame pulse
// [R2] wide-pulse pin high stops measurement; offsets still apply
// [R3] each input stream delayed forward by its offset, half-clock steps up to 4.5; code drops the offset LSB, whole-clock steps up to 4
// [R4] trigger rise after a low frame starts measurement; done two frames later
// [R5] host clears trigger before the next measurement
// [R6] negative format compares falling edges; GCI compares rising edges
// [R7] block fill writes pattern into bits 11-15, zeros into 0-10
// [R8] fill covers all locations within two frames, then clears go bit
// [R9] loopback bit routes output stream n channel m to input n channel m
// [R10] host sets all offsets to zero for loopback
// [R11] variable delay: channels n..n+2 next frame, n+3 on same frame
// [R12] constant delay: frame n data read during frame n+2
// [R13] bus style pin picks plain or multiplexed bus
// [R14] data strobe level at strobe rise picks multiplexed mode 1 or 2
// [R15] 16-bit data, 8-bit address; multiplexed shares low byte
// [R16] data memory and alignment result are read-only
// [R17] A7 low selects registers; A7 high selects a channel of picked stream
// [R18] control register holds fill mode, memory pick and stream pick
// [R19] drive pin low: standby bit gates outputs; high: outputs enabled
// [R20] per-location drive bit enables or floats its slot
// [R21] processor bit outputs location content, else switched data byte
// [R22] host keeps drive pin low while configuring
// [R23] master clock runs at twice the bit rate
// [R24] frames of 128 eight-bit channels marked by frame sync
// [R25] done flag clears when a new measurement starts
module tscc_core (
	// clock and reset
	input  wire logic       CLK,
	input  wire logic       SYS_RST,
	// serial side
	input  wire logic [3:0] RX,
	input  wire logic       FRAME_SYNC_IN,
	input  wire logic       FRAME_MEASURE_INPUT,
	input  wire logic       WIDE_PULSE_SELECT_PIN,
	input  wire logic       OUTPUT_DRIVE_PIN,
	output logic      [3:0] TX,
	output logic      [3:0] TX_OE,
	// host port
	input  wire logic       BUS_STYLE_PIN,
	input  wire logic       ADDR_STROBE_LATCH,
	input  wire logic       DATA_STROBE_READ,
	input  wire logic       RW_WR,
	input  wire logic       CS_N,
	input  wire logic [7:0] ADDR,
	input  wire logic [7:0] AD_IN,
	output logic      [7:0] AD_OUT,
	output logic            AD_OE,
	input  wire logic [7:0] DHI_IN,
	output logic      [7:0] DHI_OUT,
	output logic            DHI_OE,
	output logic            TRANSFER_ACK_N,
	output logic            TRANSFER_ACK_OE
);
	logic [tscc_pkg::SYNC_W-1:0] s1_q, s2_q, s3_q, pin_q;
	logic [3:0]  rx_f;
	logic        fs_f, fe_f, wide_f, ode_f, bus_f, as_f, ds_f, rw_f, csn_f;
	logic [7:0]  addr_f, ad_f, dhi_f;
	logic        fs_p, fe_p, as_p, gci_q, mode2_q, trig_p, low_ok_q, busy_q, got_q, done_q, nfr_q;
	logic [10:0] cnt_q, icnt;
	logic [1:0]  fidx_q, ofr, ifr;
	logic [6:0]  slot, nslot;
	logic        fedge, load, glob_en, fe_edge, meas_start;
	logic [15:0] cr_q, ims_q, offs_q, rdat, wdat, fill_word;
	logic [11:0] res_q;
	logic [15:0] cm_q [0:511];
	logic [7:0]  dm_q [0:1535];
	logic [8:0]  fill_q, cm_idx;
	logic        fill_run, act, wr, start, dm_rd, ims_wr, cm_wr;
	logic [7:0]  a, alat_q;
	tscc_pkg::tscc_port_t st_q;
	logic [7:0]  tx_sh_q [4];
	logic [3:0]  tx_oe_q;
	logic [15:0] loc_w [4];
	logic [7:0]  nbyte [4];
	logic [40:0] pw_q, fo_data;
	logic        pv_q, f_ready, fo_valid;

	// register hit for an address; A7 high never hits
	function automatic logic hit_reg(input logic [7:0] ad, input logic [6:0] r);
		hit_reg = !ad[7] && (ad[6:0] == r);
	endfunction

	// buffer index sum modulo three
	function automatic logic [1:0] add3(input logic [1:0] x, input logic [1:0] y);
		logic [2:0] s;
		s = {1'b0, x} + {1'b0, y};
		add3 = (s >= 3'd3) ? 2'(s - 3'd3) : s[1:0];
	endfunction

	// three-stage pin synchroniser; a bit changes once stages two and three agree
	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			pin_q <= '0;
		end
		else
		begin
			s1_q <= {RX, FRAME_SYNC_IN, FRAME_MEASURE_INPUT, WIDE_PULSE_SELECT_PIN,
				OUTPUT_DRIVE_PIN, BUS_STYLE_PIN, ADDR_STROBE_LATCH, DATA_STROBE_READ,
				RW_WR, CS_N, ADDR, AD_IN, DHI_IN};
			s2_q <= s1_q;
			s3_q <= s2_q;
			pin_q <= (s2_q & ~(s2_q ^ s3_q)) | (pin_q & (s2_q ^ s3_q));
		end
	end
	assign {rx_f, fs_f, fe_f, wide_f, ode_f, bus_f, as_f, ds_f, rw_f, csn_f,
		addr_f, ad_f, dhi_f} = pin_q;

	// frame edge per detected format; wide mode forces the negative format
	assign fedge = gci_q ? (fs_f & ~fs_p) : (~fs_f & fs_p);
	assign slot = cnt_q[10:4];
	assign nslot = slot + 7'd1;
	assign load = (cnt_q[3:0] == 4'hf);
	assign ofr = (nslot == 7'd0) ? add3(fidx_q, 2'h1) : fidx_q;
	assign icnt = cnt_q - tscc_pkg::INPUT_LAG;
	assign ifr = (cnt_q < tscc_pkg::INPUT_LAG) ? add3(fidx_q, 2'h2) : fidx_q;
	assign glob_en = ode_f | ims_q[tscc_pkg::IMS_STANDBY]; // [R19]

	// frame counter, triple buffer index and format detect
	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			fs_p <= 1'b1;
			cnt_q <= '0;
			fidx_q <= '0;
			gci_q <= 1'b0;
		end
		else
		begin
			fs_p <= fs_f;
			cnt_q <= fedge ? 11'h000 : cnt_q + 11'h001; // [R24]
			if (cnt_q == 11'h000)
				fidx_q <= add3(fidx_q, 2'h1);
			if (cnt_q == tscc_pkg::MID_FRAME)
				gci_q <= ~fs_f & ~wide_f;
		end
	end

	// per-stream output fetch, serialiser, loopback and input assembly
	for (genvar n = 0; n < tscc_pkg::STREAMS; n++)
	begin : g_st
		logic [1:0] rbuf;
		logic [7:0] obyte;
		logic [4:0] dl_q;
		logic [6:0] ish_q;
		logic [3:0] nib;
		logic [2:0] dly;
		logic       din, bin;
		assign loc_w[n] = cm_q[{2'(n), nslot}];
		assign rbuf = loc_w[n][tscc_pkg::CM_CONST] ? add3(ofr, 2'h1) // [R12]
			: (({1'b0, loc_w[n][6:0]} + tscc_pkg::VAR_MIN_DELAY) <= {1'b0, nslot})
			? ofr : add3(ofr, 2'h2); // [R11]
		assign obyte = loc_w[n][tscc_pkg::CM_PROC] ? loc_w[n][7:0] // [R21]
			: dm_q[{rbuf, loc_w[n][8:7], loc_w[n][6:0]}];
		assign din = cm_q[{2'(n), slot}][tscc_pkg::CM_LOOP] ? tx_sh_q[n][7] : rx_f[n]; // [R9]
		assign nib = offs_q[4*n +: 4];
		assign dly = (nib > tscc_pkg::OFFS_MAX) ? 3'd4 : nib[3:1];
		assign bin = dl_q[3'd4 - dly]; // [R3]
		assign nbyte[n] = {ish_q, bin};
		assign TX[n] = tx_sh_q[n][7];
		always_ff @(posedge CLK or posedge SYS_RST)
		begin
			if (SYS_RST)
			begin
				tx_sh_q[n] <= 8'hff;
				tx_oe_q[n] <= 1'b0;
				dl_q <= '0;
				ish_q <= '0;
			end
			else
			begin
				if (load)
				begin
					tx_sh_q[n] <= obyte;
					tx_oe_q[n] <= glob_en & loc_w[n][tscc_pkg::CM_DRIVE]; // [R20]
				end
				else if (cnt_q[0])
					tx_sh_q[n] <= {tx_sh_q[n][6:0], 1'b1};
				dl_q <= {dl_q[3:0], din};
				if (icnt[0])
					ish_q <= nbyte[n][6:0];
			end
		end
	end
	assign TX_OE = tx_oe_q;

	// completed input word waits here until the buffer takes it
	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			pv_q <= 1'b0;
			pw_q <= '0;
		end
		else if (!pv_q || f_ready)
		begin
			pv_q <= (icnt[3:0] == 4'hf);
			pw_q <= {ifr, icnt[10:4], nbyte[3], nbyte[2], nbyte[1], nbyte[0]};
		end
	end

	tscc_fifo2 #(.W(41)) u_buf (
		.clk       (CLK),
		.rst       (SYS_RST),
		.in_valid  (pv_q),
		.in_ready  (f_ready),
		.in_data   (pw_q),
		.out_valid (fo_valid),
		.out_ready (!dm_rd),
		.out_data  (fo_data)
	);

	// data memory: buffer drains when the host is not reading it
	always_ff @(posedge CLK)
	begin
		if (fo_valid && !dm_rd)
			for (int k = 0; k < tscc_pkg::STREAMS; k++)
				dm_q[{fo_data[40:39], 2'(k), fo_data[38:32]}] <= fo_data[8*k +: 8];
	end

	// host access decode for plain and multiplexed styles
	assign act = !csn_f && ((bus_f && mode2_q) ? (!ds_f || !rw_f) : ds_f); // [R13]
	assign wr = !rw_f;
	assign a = bus_f ? alat_q : addr_f; // [R15]
	assign wdat = {dhi_f, ad_f};
	assign start = (st_q == tscc_pkg::P_IDLE) && act;
	assign dm_rd = start && !wr && a[7] && cr_q[tscc_pkg::CR_MEMPICK];
	assign ims_wr = start && wr && hit_reg(a, tscc_pkg::REG_MODE);
	assign cm_idx = {cr_q[tscc_pkg::CR_STREAM +: 2], a[6:0]}; // [R17]
	assign fill_run = ims_q[tscc_pkg::IMS_GO] && cr_q[tscc_pkg::CR_FILLMODE];
	assign cm_wr = start && wr && a[7] && !cr_q[tscc_pkg::CR_MEMPICK] && !fill_run; // [R16]
	assign fill_word = {ims_q[tscc_pkg::IMS_PAT +: 5], tscc_pkg::CM_FILL_ZERO};

	// read mux
	always_comb
	begin
		rdat = 16'h0000;
		if (a[7])
			rdat = cr_q[tscc_pkg::CR_MEMPICK]
				? {8'h00, dm_q[{add3(fidx_q, 2'h2), cm_idx}]} : cm_q[cm_idx];
		else if (hit_reg(a, tscc_pkg::REG_CTRL))
			rdat = cr_q;
		else if (hit_reg(a, tscc_pkg::REG_MODE))
			rdat = ims_q;
		else if (hit_reg(a, tscc_pkg::REG_FAR))
			rdat = {3'b000, done_q, res_q};
		else if (hit_reg(a, tscc_pkg::REG_OFFS))
			rdat = offs_q;
	end

	// address latch and multiplexed mode pick
	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			as_p <= 1'b0;
			mode2_q <= 1'b0;
			alat_q <= '0;
		end
		else
		begin
			as_p <= as_f;
			if (bus_f && as_f && !as_p)
				mode2_q <= ds_f; // [R14]
			if (bus_f && !as_f && as_p)
				alat_q <= ad_f; // all eight bits, so A7 reaches memory [R15]
		end
	end

	// port sequence: acknowledge low, then high for one cycle, then release
	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			st_q <= tscc_pkg::P_IDLE;
			TRANSFER_ACK_N <= 1'b1;
			TRANSFER_ACK_OE <= 1'b0;
			AD_OUT <= '0;
			DHI_OUT <= '0;
			AD_OE <= 1'b0;
			DHI_OE <= 1'b0;
		end
		else
		begin
			unique case (st_q)
				tscc_pkg::P_IDLE:
				begin
					if (act)
					begin
						st_q <= tscc_pkg::P_ACT;
						TRANSFER_ACK_N <= 1'b0;
						TRANSFER_ACK_OE <= 1'b1;
						AD_OUT <= rdat[7:0];
						DHI_OUT <= rdat[15:8];
						AD_OE <= !wr;
						DHI_OE <= !wr;
					end
				end
				tscc_pkg::P_ACT:
				begin
					if (!act)
					begin
						st_q <= tscc_pkg::P_END;
						TRANSFER_ACK_N <= 1'b1;
						AD_OE <= 1'b0;
						DHI_OE <= 1'b0;
					end
				end
				tscc_pkg::P_END:
				begin
					st_q <= tscc_pkg::P_IDLE;
					TRANSFER_ACK_OE <= 1'b0;
				end
			endcase
		end
	end

	// control, offset and mode registers; a host write of go wins over the clear
	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			cr_q <= tscc_pkg::CR_RST;
			ims_q <= tscc_pkg::IMS_RST;
			offs_q <= tscc_pkg::OFFS_RST;
		end
		else
		begin
			if (start && wr && hit_reg(a, tscc_pkg::REG_CTRL))
				cr_q <= wdat; // [R18]
			if (start && wr && hit_reg(a, tscc_pkg::REG_OFFS))
				offs_q <= wdat;
			if (ims_wr)
				ims_q <= wdat;
			else if (fill_run && fill_q == tscc_pkg::FILL_LAST)
				ims_q[tscc_pkg::IMS_GO] <= 1'b0; // [R8]
		end
	end

	// fill address walks one location per clock
	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
			fill_q <= '0;
		else
			fill_q <= fill_run ? fill_q + 9'd1 : 9'd0;
	end

	// connection memory write port: block fill or host
	always_ff @(posedge CLK)
	begin
		if (fill_run)
			cm_q[fill_q] <= fill_word; // [R7]
		else if (cm_wr)
			cm_q[cm_idx] <= wdat;
	end

	// frame alignment measurement
	assign fe_edge = gci_q ? (fe_f & ~fe_p) : (~fe_f & fe_p); // [R6]
	assign meas_start = ims_q[tscc_pkg::IMS_TRIG] && !trig_p && low_ok_q && !wide_f; // [R2]
	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			fe_p <= 1'b0;
			trig_p <= 1'b0;
			low_ok_q <= 1'b0;
			busy_q <= 1'b0;
			got_q <= 1'b0;
			nfr_q <= 1'b0;
			done_q <= 1'b0;
			res_q <= '0;
		end
		else
		begin
			fe_p <= fe_f;
			trig_p <= ims_q[tscc_pkg::IMS_TRIG];
			if (ims_q[tscc_pkg::IMS_TRIG])
				low_ok_q <= 1'b0;
			else if (cnt_q == 11'h000)
				low_ok_q <= 1'b1;
			if (meas_start)
			begin
				busy_q <= 1'b1; // [R4]
				done_q <= 1'b0; // [R25]
				got_q <= 1'b0;
				nfr_q <= 1'b0;
			end
			else if (busy_q && wide_f)
				busy_q <= 1'b0;
			else if (busy_q)
			begin
				if (fe_edge && nfr_q && !got_q)
				begin
					res_q <= {1'b0, cnt_q};
					got_q <= 1'b1;
				end
				if (cnt_q == 11'h000)
				begin
					nfr_q <= 1'b1;
					busy_q <= !nfr_q;
					done_q <= nfr_q; // [R4]
				end
			end
		end
	end

	// checks
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SYS_RST);

	sequence s_last_fill;
		fill_run && fill_q == tscc_pkg::FILL_LAST && !ims_wr;
	endsequence
	sequence s_meas_end;
		busy_q && !wide_f ##1 !busy_q && !meas_start;
	endsequence

	AST_FILL_PATTERN: assert property (fill_run |=> cm_q[$past(fill_q)] == $past(fill_word)) // [R7]
		else $error("block fill wrote a wrong word");
	AST_FILL_END: assert property (s_last_fill |=> !ims_q[tscc_pkg::IMS_GO]) // [R8]
		else $error("go bit not cleared after fill");
	AST_MEAS_CLEAR: assert property (meas_start |=> busy_q && !done_q) // [R25]
		else $error("done flag survived a new start");
	AST_MEAS_DONE: assert property (s_meas_end |-> done_q) // [R4]
		else $error("measurement ended without done");
	AST_WIDE_OFF: assert property (wide_f |=> !busy_q) // [R2]
		else $error("measurement running in wide mode");
	AST_STANDBY: assert property (load && !ode_f && !ims_q[tscc_pkg::IMS_STANDBY] // [R19]
		|=> TX_OE == 4'h0)
		else $error("outputs driven while globally off");
	AST_PROC_BYTE: assert property (load && loc_w[0][tscc_pkg::CM_PROC] // [R21]
		|=> tx_sh_q[0] == 8'($past(loc_w[0])))
		else $error("processor byte not loaded");
	AST_ACK: assert property (start |=> !TRANSFER_ACK_N && TRANSFER_ACK_OE) // [R13]
		else $error("access not acknowledged");
	AST_MODE: assert property (bus_f && as_f && !as_p |=> mode2_q == $past(ds_f)) // [R14]
		else $error("multiplexed mode pick wrong");
	AST_CM_WRITE: assert property (cm_wr |=> cm_q[$past(cm_idx)] == $past(wdat)) // [R17]
		else $error("connection write lost");
	AST_FAR_RO: assert property (start && wr && hit_reg(a, tscc_pkg::REG_FAR) && !busy_q // [R16]
		|=> $stable(res_q))
		else $error("alignment result written by host");
endmodule
`default_nettype wire

// file: test/tscc_host_model.sv
// host processor model for the switch core's parallel port
// assumes the bench resolves the shared data wires and the acknowledge pull-up
`timescale 1ns/100ps
`default_nettype none
module tscc_host_model (
	// clock
	input  wire logic       clk,
	// port controls
	output logic            style = 1'b0,
	output logic            ale   = 1'b0,
	output logic            ds    = 1'b0,
	output logic            rw    = 1'b1,
	output logic            cs_n  = 1'b1,
	// address and data drive
	output logic [7:0]      addr  = 8'h00,
	output logic [7:0]      ad    = 8'h00,
	output logic [7:0]      dhi   = 8'h00,
	output logic            en    = 1'b0,
	// answer side
	input  wire logic       ack_n,
	input  wire logic [7:0] ad_w,
	input  wire logic [7:0] dhi_w
);
	// hold a phase long enough for the pin synchronisers
	task automatic wt();
		repeat (5) @(posedge clk);
		#1;
	endtask

	// one cycle: m 0 plain, 1 multiplexed mode 1, 2 multiplexed mode 2
	task automatic acc(input logic [1:0] m, input logic wr, input logic [7:0] a,
		input logic [15:0] wd, output logic [15:0] rd, output logic ok);
		int n;
		n = 0;
		style = (m != 2'h0);
		ds = (m == 2'h2); // idle level picks the multiplexed timing
		rw = (m == 2'h2) | !wr;
		addr = a;
		ad = a;
		en = 1'b1;
		wt();
		if (m != 2'h0)
		begin
			ale = 1'b1;
			wt();
			ale = 1'b0;
			wt();
		end
		ad = wd[7:0]; // low byte shared with address in multiplexed style
		dhi = wd[15:8];
		en = wr;
		wt();
		cs_n = 1'b0;
		rw = !wr;
		ds = (m == 2'h2) ? wr : 1'b1;
		@(posedge clk);
		while (ack_n !== 1'b0 && n < 40)
		begin
			@(posedge clk);
			n++;
		end
		rd = {dhi_w, ad_w};
		ok = (n < 40);
		#1;
		cs_n = 1'b1;
		rw = 1'b1;
		ds = (m == 2'h2);
		en = 1'b0;
		repeat (8) @(posedge clk);
		#1;
	endtask
endmodule
`default_nettype wire

// file: test/test_tscc_core.sv
// self-checking bench for the switch control core
// assumes the host model for port cycles and a local frame pulse source
`timescale 1ns/100ps
`default_nettype none
module test_tscc_core;
	logic        clk  = 1'b0;
	logic        rst  = 1'b1;
	logic        wide = 1'b0;
	logic        odrv = 1'b0; // outputs held off while configuring
	logic [10:0] fc   = 11'h000;
	logic        fsync, fmeas, ack_w, ack_n, ack_oe, ad_oe, dhi_oe;
	logic        h_style, h_ale, h_ds, h_rw, h_cs_n, h_en, ok;
	logic [7:0]  h_addr, h_ad, h_dhi, ad_out, dhi_out, ad_w, dhi_w;
	logic [3:0]  tx, tx_oe;
	logic [15:0] rv;
	int          err_count = 0;
	int          checks    = 0;
	int          cyc       = 0;

	// master clock
	always #20 clk = ~clk;

	// frame counter; negative frame pulse, measured edge or quarter-rate clock
	always @(posedge clk)
		fc <= #1 fc + 11'h001;
	assign fsync = (fc > 11'h001);
	assign fmeas = wide ? fc[1] : !(fc >= 11'h12c && fc < 11'h134);

	// shared wires: released data shows the inverse, acknowledge is pulled up
	assign ad_w  = ad_oe ? ad_out : (h_en ? h_ad : ~h_ad);
	assign dhi_w = dhi_oe ? dhi_out : (h_en ? h_dhi : ~h_dhi);
	assign ack_w = ack_oe ? ack_n : 1'b1;

	tscc_core dut (
		.CLK(clk), .SYS_RST(rst), .RX(4'h5), .FRAME_SYNC_IN(fsync),
		.FRAME_MEASURE_INPUT(fmeas), .WIDE_PULSE_SELECT_PIN(wide), .OUTPUT_DRIVE_PIN(odrv),
		.TX(tx), .TX_OE(tx_oe), .BUS_STYLE_PIN(h_style), .ADDR_STROBE_LATCH(h_ale),
		.DATA_STROBE_READ(h_ds), .RW_WR(h_rw), .CS_N(h_cs_n), .ADDR(h_addr), .AD_IN(ad_w),
		.AD_OUT(ad_out), .AD_OE(ad_oe), .DHI_IN(dhi_w), .DHI_OUT(dhi_out), .DHI_OE(dhi_oe),
		.TRANSFER_ACK_N(ack_n), .TRANSFER_ACK_OE(ack_oe)
	);

	tscc_host_model host (
		.clk(clk), .style(h_style), .ale(h_ale), .ds(h_ds), .rw(h_rw), .cs_n(h_cs_n),
		.addr(h_addr), .ad(h_ad), .dhi(h_dhi), .en(h_en), .ack_n(ack_w), .ad_w(ad_w),
		.dhi_w(dhi_w)
	);

	// verdict and end of run
	task automatic stop_test();
		if (err_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// cut a hang short
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 70000)
		begin
			err_count++;
			stop_test();
		end
	end

	// compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// port cycles with acknowledge check
	task automatic wr(input logic [1:0] m, input logic [7:0] a, input logic [15:0] d);
		host.acc(m, 1'b1, a, d, rv, ok);
		chk({15'h0000, ok}, 16'h0001);
	endtask
	task automatic rd(input logic [1:0] m, input logic [7:0] a, input logic [15:0] e);
		host.acc(m, 1'b0, a, 16'h0000, rv, ok);
		chk({15'h0000, ok}, 16'h0001);
		chk(rv, e);
	endtask
	task automatic frame_align_result(input logic [15:0] e);
		host.acc(2'h0, 1'b0, 8'h02, 16'h0000, rv, ok);
		chk({15'h0000, ok}, 16'h0001);
		chk(rv & 16'h1000, e);
	endtask

	// wait for settings to land, then count drive and ones on stream 0 for a frame
	task automatic scan(input logic [15:0] e_oe, input logic [15:0] e_one);
		logic [15:0] n_oe;
		logic [15:0] n_one;
		n_oe = 16'h0000;
		n_one = 16'h0000;
		repeat (2048) @(posedge clk);
		repeat (2048)
		begin
			@(negedge clk);
			n_oe = n_oe + {15'h0000, tx_oe[0] === 1'b1};
			n_one = n_one + {15'h0000, tx_oe[0] === 1'b1 && tx[0] === 1'b1};
		end
		chk(n_oe, e_oe);
		chk(n_one, e_one);
		@(posedge clk);
		#1;
	endtask

	initial
	begin
		repeat (4) @(posedge clk);
		#1;
		rst = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		// reset values, unmapped place, read-only result
		rd(2'h0, 8'h00, 16'h0000);
		rd(2'h0, 8'h01, 16'h0000);
		wr(2'h0, 8'h04, 16'h5555);
		rd(2'h0, 8'h04, 16'h0000);
		wr(2'h0, 8'h02, 16'hffff);
		frame_align_result(16'h0000);
		// offsets through plain and both multiplexed timings
		wr(2'h0, 8'h03, 16'h9876);
		rd(2'h0, 8'h03, 16'h9876);
		wr(2'h1, 8'h03, 16'h1234);
		rd(2'h2, 8'h03, 16'h1234);
		wr(2'h2, 8'h03, 16'h0000);
		rd(2'h1, 8'h03, 16'h0000);
		// block fill of processor and drive bits, go bit clears itself
		wr(2'h0, 8'h00, 16'h0020);
		wr(2'h0, 8'h01, 16'h00a4);
		repeat (4096) @(posedge clk);
		#1;
		rd(2'h0, 8'h01, 16'h00a0);
		for (int s = 0; s < 4; s++)
		begin
			wr(2'h0, 8'h00, {14'h0000, s[1:0]});
			rd(2'h0, 8'h80, 16'h2800);
			rd(2'h0, 8'hff, 16'h2800);
			wr(2'h0, 8'h00, {11'h000, 3'h4, s[1:0]});
			rd(2'h0, 8'h87, {8'h00, {8{~s[0]}}});
			wr(2'h0, 8'h87, 16'h1234);
			rd(2'h0, 8'h87, {8'h00, {8{~s[0]}}});
		end
		// stream 0: one floated slot, a5 slot, two slots switched from stream 2 (all ones)
		wr(2'h0, 8'h00, 16'h0000);
		wr(2'h0, 8'h8a, 16'h0800);
		wr(2'h0, 8'h94, 16'h28a5);
		wr(2'h0, 8'hb0, 16'h2105);
		wr(2'h0, 8'hb1, 16'h3105);
		scan(16'h0000, 16'h0000);
		wr(2'h0, 8'h01, 16'h0002);
		scan(16'h07f0, 16'h0028);
		odrv = 1'b1;
		wr(2'h0, 8'h01, 16'h0000);
		scan(16'h07f0, 16'h0028);
		// loopback: a processor byte sent on stream 0 channel 21 returns as its input
		wr(2'h0, 8'ha1, 16'h683c);
		repeat (4096) @(posedge clk);
		#1;
		wr(2'h0, 8'h00, 16'h0010);
		rd(2'h0, 8'ha1, 16'h003c);
		// no measurement in wide-frame mode
		wide = 1'b1;
		repeat (2048) @(posedge clk);
		#1;
		wr(2'h0, 8'h01, 16'h0001);
		repeat (6144) @(posedge clk);
		#1;
		frame_align_result(16'h0000);
		// falling edges measured, done two frames after start
		wide = 1'b0;
		wr(2'h0, 8'h01, 16'h0000);
		repeat (2048) @(posedge clk);
		#1;
		wr(2'h0, 8'h01, 16'h0001);
		repeat (6144) @(posedge clk);
		#1;
		frame_align_result(16'h1000);
		chk({15'h0000, rv[11:0] >= 12'h12b && rv[11:0] <= 12'h12d}, 16'h0001);
		// a fresh start drops the stale done flag
		wr(2'h0, 8'h01, 16'h0000);
		repeat (2048) @(posedge clk);
		#1;
		wr(2'h0, 8'h01, 16'h0001);
		frame_align_result(16'h0000);
		stop_test();
	end
endmodule
`default_nettype wire
